// ### design/dtc_defines.svh
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

// Register indices within one channel's block of I/O words
`define DTC_LEN_IDX     16'h0004
`define DTC_CTRL_IDX    16'h0005

// Reset values
`define DTC_LEN_RESET   16'h0000
`define DTC_CTRL_RESET  16'h0000

// Control word field positions (most significant bit of each field)
`define DTC_EN_BIT      15
`define DTC_STATUS_BIT  14
`define DTC_IRQEN_BIT   13
`define DTC_RELOAD_BIT  12
`define DTC_DSTMODE_MSB 9
`define DTC_SRCMODE_MSB 7
`define DTC_BURST_MSB   5
`define DTC_SYNC_BIT    2
`define DTC_LASTHALF_BIT 1
`define DTC_PINGPONG_BIT 0

// Addressing modes and burst limits
`define DTC_MODE_INC    2'h0
`define DTC_MODE_FIXED  2'h2
`define DTC_MAX_BURST   3'h4
`define DTC_WORD_BYTES  32'h0000_0004

`endif

// ### design/dtc_pkg.sv
package dtc_pkg;

    // Channel control word, bit 15 down to bit 0
    typedef struct packed {
        logic       enable;
        logic       status;
        logic       irqEn;
        logic       autoReload;
        logic [1:0] rsvd;
        logic [1:0] dstMode;
        logic [1:0] srcMode;
        logic [2:0] burstSel;
        logic       syncEn;
        logic       lastHalf;
        logic       pingPong;
    } dtc_ctrl_t;

    // Register port request from the I/O space
    typedef struct packed {
        logic        write;
        logic        read;
        logic [15:0] addr;
        logic [15:0] data;
    } dtc_reg_req_t;

    // Channel service sequencer
    typedef enum logic [1:0] {
        DTC_IDLE,
        DTC_BURST,
        DTC_DRAIN
    } dtc_state_t;

endpackage : dtc_pkg

// ### design/dtc_fifo.sv
`timescale 1ns/1ps

module dtc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Filling side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Draining side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    wire              push = inValid && inReady;
    wire              pop  = outValid && outReady;

    // Full and empty come straight from the occupancy count
    assign inReady  = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];

    // Storage carries no reset; only pointers and the count are control state
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    // Pointers wrap explicitly so depth need not be a power of two
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : dtc_fifo

// ### design/dtc_channel.sv
// Notes on behaviour
// - In ping-pong mode the length covers both halves together.
// - The length register never changes while serving; a separate counter counts down.
// - Enable clears by itself when a block transfer without auto reload finishes.
// - Disabled channel gets no service, but a running burst completes.
// - Once enabled with sync off, the channel requests service at the next free slot.
// - Status sets on nonzero length write, or control write with nonzero length.
// - Status clears when all bytes moved without auto reload, or length zero is written.
// - With interrupt enable set, block completion raises the interrupt request.
// - Auto reload restores addresses and count and restarts after completion.
// - Destination mode 0 increments by four per transfer, 2h keeps it fixed.
// - Source mode 0 increments the source address by four per transfer.
// - Burst field gives 1, 2, 4, 8 or 16 double words per service.
// - Sync off starts at enable; sync on runs one burst per event.
// - Read-only bit 1 tells which ping-pong half finished last.
// - Bit 0 turns ping-pong mode on or off.
`timescale 1ns/1ps
`include "dtc_defines.svh"

module dtc_channel
    import dtc_pkg::*;
#(
    parameter int ADDR_W     = 32,
    parameter int DATA_W     = 32,
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // Register port
    input  wire dtc_reg_req_t      regReq,
    output logic [15:0]            regRdata,
    // Start addresses and event selection from neighbouring logic
    input  wire logic [ADDR_W-1:0] srcStart,
    input  wire logic [ADDR_W-1:0] dstStart,
    input  wire logic              syncEvent,
    // Arbitration
    output logic                   serviceReq,
    input  wire logic              serviceGrant,
    // Source read port
    output logic                   rdReq,
    output logic [ADDR_W-1:0]      rdAddr,
    input  wire logic              rdAck,
    input  wire logic [DATA_W-1:0] rdData,
    // Destination write port
    output logic                   wrValid,
    output logic [ADDR_W-1:0]      wrAddr,
    output logic [DATA_W-1:0]      wrData,
    input  wire logic              wrReady,
    // Completion
    output logic                   channelIrq
);
    dtc_ctrl_t   ctrl;
    dtc_ctrl_t   next_ctrl;
    dtc_ctrl_t   wdCtrl;
    dtc_state_t  state;
    logic [15:0] lengthReg;
    logic [15:0] remaining;
    logic [4:0]  rdLeft;
    logic [4:0]  wrLeft;
    logic        eventPending;
    logic        fifoInReady;
    logic        fifoOutValid;

    // Register decode
    wire         lenWrite  = regReq.write && (regReq.addr == `DTC_LEN_IDX);
    wire         ctrlWrite = regReq.write && (regReq.addr == `DTC_CTRL_IDX);
    wire         lenRead   = regReq.read && (regReq.addr == `DTC_LEN_IDX);
    wire         ctrlRead  = regReq.read && (regReq.addr == `DTC_CTRL_IDX);
    assign wdCtrl = dtc_ctrl_t'(regReq.data);

    // Burst size; reserved codes fall back to the largest burst
    wire [2:0]   burstEff   = (ctrl.burstSel > `DTC_MAX_BURST) ? `DTC_MAX_BURST : ctrl.burstSel;
    wire [4:0]   burstWords = 5'h01 << burstEff;
    wire [15:0]  burstBytes = {9'h000, burstWords, 2'b00};
    wire [15:0]  halfLen    = {1'b0, lengthReg[15:1]};

    // Service eligibility and sequencing
    wire         startReq   = ctrlWrite && wdCtrl.enable && !ctrl.enable;
    wire         eligible   = ctrl.enable && ctrl.status && (!ctrl.syncEn || eventPending);
    assign serviceReq = (state == DTC_IDLE) && eligible;
    wire         grantTaken = serviceReq && serviceGrant;
    assign rdReq = (state == DTC_BURST) && (rdLeft != 5'h00) && fifoInReady;
    wire         rdBeat     = rdReq && rdAck;
    assign wrValid = fifoOutValid;
    wire         wrBeat     = wrValid && wrReady;
    wire         burstEnd   = (state == DTC_DRAIN) && wrBeat && (wrLeft == 5'h01);
    wire         blockDone  = burstEnd && (remaining <= burstBytes);
    wire [15:0]  remAfter   = remaining - burstBytes;
    wire         halfDone   = burstEnd && ctrl.pingPong && !blockDone
                              && (remaining > halfLen) && (remAfter <= halfLen);
    wire         reload     = blockDone && ctrl.autoReload;

    // Address steps; reserved mode codes hold the address like mode 2h
    wire [ADDR_W-1:0] srcStep = (ctrl.srcMode == `DTC_MODE_INC) ? ADDR_W'(`DTC_WORD_BYTES) : '0;
    wire [ADDR_W-1:0] dstStep = (ctrl.dstMode == `DTC_MODE_INC) ? ADDR_W'(`DTC_WORD_BYTES) : '0;

    // Data path buffer between source reads and destination writes
    dtc_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock    (clock),
        .rst_n    (rst_n),
        .inValid  (rdBeat),
        .inReady  (fifoInReady),
        .inData   (rdData),
        .outValid (fifoOutValid),
        .outReady (wrReady),
        .outData  (wrData)
    );

    // Control word next value: hardware events first, software writes last
    always_comb begin
        next_ctrl = ctrl;
        if (blockDone) begin
            if (ctrl.pingPong) begin
                next_ctrl.lastHalf = 1'b1;
            end
            if (!ctrl.autoReload) begin
                next_ctrl.enable = 1'b0;
                next_ctrl.status = 1'b0;
            end
        end
        if (halfDone) begin
            next_ctrl.lastHalf = 1'b0;
        end
        if (ctrlWrite) begin
            // Software may set enable in the very cycle hardware clears it
            next_ctrl          = wdCtrl;
            next_ctrl.status   = (lengthReg != 16'h0000) ? 1'b1 : ctrl.status;
            if (blockDone && !ctrl.autoReload && lengthReg == 16'h0000) begin
                next_ctrl.status = 1'b0;
            end
            next_ctrl.lastHalf = blockDone ? (ctrl.pingPong || ctrl.lastHalf)
                               : (halfDone ? 1'b0 : ctrl.lastHalf);
        end
        if (lenWrite) begin
            next_ctrl.status = (regReq.data != 16'h0000);
        end
    end

    // Registers seen by software
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lengthReg <= `DTC_LEN_RESET;
            ctrl      <= dtc_ctrl_t'(`DTC_CTRL_RESET);
        end else begin
            if (lenWrite) begin
                lengthReg <= regReq.data;
            end
            ctrl <= next_ctrl;
        end
    end

    // Read data is registered and appears the cycle after the read strobe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 16'h0000;
        end else if (lenRead) begin
            regRdata <= lengthReg;
        end else if (ctrlRead) begin
            regRdata <= ctrl;
        end else if (regReq.read) begin
            regRdata <= 16'h0000;
        end
    end

    // Sequencer; enable is only checked at grant so a burst runs to its end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= DTC_IDLE;
        end else begin
            case (state)
                DTC_IDLE: begin
                    if (grantTaken) begin
                        state <= DTC_BURST;
                    end
                end
                DTC_BURST: begin
                    if (rdBeat && rdLeft == 5'h01) begin
                        state <= DTC_DRAIN;
                    end
                end
                DTC_DRAIN: begin
                    if (burstEnd) begin
                        state <= DTC_IDLE;
                    end
                end
                default: begin
                    state <= DTC_IDLE;
                end
            endcase
        end
    end

    // Beat counters for the current burst
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdLeft <= 5'h00;
            wrLeft <= 5'h00;
        end else if (grantTaken) begin
            rdLeft <= burstWords;
            wrLeft <= burstWords;
        end else begin
            if (rdBeat) begin
                rdLeft <= rdLeft - 5'h01;
            end
            if (wrBeat && state != DTC_IDLE) begin
                wrLeft <= wrLeft - 5'h01;
            end
        end
    end

    // Remaining bytes live here so the length register stays as written
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            remaining <= 16'h0000;
        end else if (startReq || reload) begin
            remaining <= lengthReg;
        end else if (blockDone) begin
            remaining <= 16'h0000;
        end else if (burstEnd) begin
            remaining <= remAfter;
        end
    end

    // Address counters, reloaded from the start values on start and reload
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdAddr <= '0;
            wrAddr <= '0;
        end else begin
            if (startReq || reload) begin
                rdAddr <= srcStart;
            end else if (rdBeat) begin
                rdAddr <= rdAddr + srcStep;
            end
            if (startReq || reload) begin
                wrAddr <= dstStart;
            end else if (wrBeat) begin
                wrAddr <= wrAddr + dstStep;
            end
        end
    end

    // Event latch: a new event beats the clear taken at grant
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            eventPending <= 1'b0;
        end else begin
            eventPending <= syncEvent || (eventPending && !grantTaken);
        end
    end

    // Completion request, masked here by the interrupt enable bit
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            channelIrq <= 1'b0;
        end else begin
            channelIrq <= ctrl.irqEn && (blockDone || halfDone);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_grant;
        (state == DTC_IDLE) && serviceReq && serviceGrant;
    endsequence

    // A mid-block burst end followed by the return to idle
    sequence s_burst_close;
        burstEnd && !blockDone && !startReq ##1 (state == DTC_IDLE);
    endsequence

    property p_en_clear;
        blockDone && !ctrl.autoReload && !ctrlWrite |=> !ctrl.enable && !serviceReq;
    endproperty
    a_en_clear: assert property (p_en_clear) else $error("enable kept after block end");

    property p_len_stable;
        !lenWrite |=> $stable(lengthReg);
    endproperty
    a_len_stable: assert property (p_len_stable) else $error("length changed by hardware");

    property p_status_set;
        lenWrite && regReq.data != 16'h0000 |=> ctrl.status;
    endproperty
    a_status_set: assert property (p_status_set) else $error("status not set");

    property p_status_clr;
        (lenWrite && regReq.data == 16'h0000) or (blockDone && !ctrl.autoReload && !regReq.write)
            |=> !ctrl.status;
    endproperty
    a_status_clr: assert property (p_status_clr) else $error("status not cleared");

    property p_burst_runs;
        s_grant |=> (state == DTC_BURST) && rdLeft == $past(burstWords);
    endproperty
    a_burst_runs: assert property (p_burst_runs) else $error("burst did not start");

    property p_no_service_off;
        !ctrl.enable |-> !serviceReq;
    endproperty
    a_no_service_off: assert property (p_no_service_off) else $error("disabled channel served");

    property p_burst_finishes;
        (state == DTC_DRAIN) && !ctrl.enable && !burstEnd |=> state == DTC_DRAIN;
    endproperty
    a_burst_finishes: assert property (p_burst_finishes) else $error("burst cut short");

    property p_sync_wait;
        serviceReq && ctrl.syncEn |-> eventPending;
    endproperty
    a_sync_wait: assert property (p_sync_wait) else $error("service without event");

    property p_irq;
        blockDone && ctrl.irqEn |=> channelIrq;
    endproperty
    a_irq: assert property (p_irq) else $error("missing completion request");

    property p_reload;
        reload && !regReq.write |=> ctrl.enable && remaining == lengthReg && rdAddr == $past(srcStart);
    endproperty
    a_reload: assert property (p_reload) else $error("reload failed");

    property p_dst_inc;
        wrBeat && !startReq && !reload && ctrl.dstMode == `DTC_MODE_INC
            |=> wrAddr == $past(wrAddr) + ADDR_W'(`DTC_WORD_BYTES);
    endproperty
    a_dst_inc: assert property (p_dst_inc) else $error("destination step wrong");

    property p_src_fixed;
        rdBeat && !startReq && !reload && ctrl.srcMode == `DTC_MODE_FIXED |=> $stable(rdAddr);
    endproperty
    a_src_fixed: assert property (p_src_fixed) else $error("source moved in fixed mode");

    property p_remaining;
        s_burst_close |-> remaining == $past(remAfter);
    endproperty
    a_remaining: assert property (p_remaining) else $error("remaining count wrong");

endmodule : dtc_channel

// ### tb/dtc_mem_model.sv
`timescale 1ns/1ps

module dtc_mem_model (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Pace control from the bench
    input  wire logic        slow,
    input  wire logic        wrHold,
    // Source read port
    input  wire logic        rdReq,
    input  wire logic [31:0] rdAddr,
    output logic             rdAck,
    output logic [31:0]      rdData,
    // Destination write port
    output logic             wrReady
);
    logic        tgl;
    logic [31:0] junk;

    // Pace bit and idle noise; the noise changes every cycle so stale data never passes by luck
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tgl  <= 1'b0;
            junk <= 32'h0000_0000;
        end else begin
            tgl  <= ~tgl;
            junk <= junk + 32'h9e37_79b9;
        end
    end

    // Slow mode answers every other cycle on each side, in opposite phases
    assign rdAck   = rdReq & (~slow | tgl);
    assign rdData  = rdAck ? {rdAddr[15:0], ~rdAddr[15:0]} : junk;
    assign wrReady = ~wrHold & (~slow | ~tgl);
endmodule : dtc_mem_model

// ### tb/dtc_channel_test.sv
`timescale 1ns/1ps
`include "dtc_defines.svh"

module dtc_channel_test
    import dtc_pkg::*;
;
    logic         clock = 1'b0;
    logic         rst_n = 1'b0;
    dtc_reg_req_t regReq = '0;
    logic [15:0]  regRdata;
    logic [31:0]  srcStart = 32'h0000_1000;
    logic [31:0]  dstStart = 32'h0000_2000;
    logic         syncEvent = 1'b0;
    logic         serviceReq;
    logic         serviceGrant = 1'b0;
    logic         rdReq;
    logic         rdAck;
    logic         wrValid;
    logic         wrReady;
    logic         channelIrq;
    logic         slow = 1'b0;
    logic         wrHold = 1'b0;
    logic [31:0]  rdAddr;
    logic [31:0]  rdData;
    logic [31:0]  wrAddr;
    logic [31:0]  wrData;
    logic [31:0]  expSrc;
    logic [31:0]  expDst;
    logic [31:0]  srcStep;
    logic [31:0]  dstStep;
    logic [15:0]  curLen;
    int           num_errors = 0;
    int           checks = 0;
    int           wrCnt = 0;
    int           irqCnt = 0;
    int           gntCnt = 0;
    int           ackCnt = 0;

    dtc_channel u_dtc_channel (.clock(clock), .rst_n(rst_n), .regReq(regReq), .regRdata(regRdata),
        .srcStart(srcStart), .dstStart(dstStart), .syncEvent(syncEvent), .serviceReq(serviceReq),
        .serviceGrant(serviceGrant), .rdReq(rdReq), .rdAddr(rdAddr), .rdAck(rdAck), .rdData(rdData),
        .wrValid(wrValid), .wrAddr(wrAddr), .wrData(wrData), .wrReady(wrReady), .channelIrq(channelIrq));

    dtc_mem_model u_dtc_mem_model (.clock(clock), .rst_n(rst_n), .slow(slow), .wrHold(wrHold),
        .rdReq(rdReq), .rdAddr(rdAddr), .rdAck(rdAck), .rdData(rdData), .wrReady(wrReady));

    always #20 clock = ~clock;

    // Arbiter stand-in: a one-cycle grant a cycle after each request is seen
    always @(posedge clock) serviceGrant <= #1 (serviceReq === 1'b1) & ~serviceGrant;

    // Monitor counting handshakes and checking every destination write
    always @(posedge clock) begin
        if (serviceReq === 1'b1 && serviceGrant === 1'b1) gntCnt++;
        if (rdReq === 1'b1 && rdAck === 1'b1) ackCnt++;
        if (channelIrq === 1'b1) irqCnt++;
        if (wrValid === 1'b1 && wrReady === 1'b1) begin
            cmp32("wrAddr", expDst, wrAddr);
            cmp32("wrData", {expSrc[15:0], ~expSrc[15:0]}, wrData);
            expDst += dstStep;
            expSrc += srcStep;
            wrCnt++;
        end
    end

    task automatic cmp16(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp16

    task automatic cmp32(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp32

    task automatic cmpCnt(input string name, input int exp, input int got);
        checks++;
        if (got != exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
        end
    endtask : cmpCnt

    task automatic clk(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : clk

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clock);
        #1 regReq = '{write: 1'b1, read: 1'b0, addr: a, data: d};
        @(posedge clock);
        #1 regReq = '0;
    endtask : wr

    task automatic rdChk(input logic [15:0] a, input logic [15:0] exp, input string name);
        @(posedge clock);
        #1 regReq = '{write: 1'b0, read: 1'b1, addr: a, data: 16'h0000};
        @(posedge clock);
        #1 regReq = '0;
        cmp16(name, exp, regRdata);
    endtask : rdChk

    // One-cycle event pulse
    task automatic pulse;
        @(posedge clock);
        #1 syncEvent = 1'b1;
        @(posedge clock);
        #1 syncEvent = 1'b0;
    endtask : pulse

    // Program a block; expected address steps follow the mode fields of the control word
    task automatic go(input logic [15:0] len, input logic [15:0] ctrl);
        expSrc  = srcStart;
        expDst  = dstStart;
        srcStep = (ctrl[7:6] == `DTC_MODE_INC) ? `DTC_WORD_BYTES : 32'h0000_0000;
        dstStep = (ctrl[9:8] == `DTC_MODE_INC) ? `DTC_WORD_BYTES : 32'h0000_0000;
        wrCnt   = 0;
        irqCnt  = 0;
        gntCnt  = 0;
        ackCnt  = 0;
        curLen  = len;
        wr(`DTC_LEN_IDX, len);
        wr(`DTC_CTRL_IDX, ctrl);
    endtask : go

    // Bounded wait for a write count, then a few cycles for completion to settle
    task automatic waitWr(input int n);
        for (int i = 0; i < 3000 && wrCnt < n; i++) @(posedge clock);
        clk(4);
        cmpCnt("writes", n, wrCnt);
    endtask : waitWr

    task automatic fin(input int nWr, input int nIrq, input int nGnt, input logic [15:0] ctrlExp);
        waitWr(nWr);
        cmpCnt("irqs", nIrq, irqCnt);
        cmpCnt("grants", nGnt, gntCnt);
        rdChk(`DTC_CTRL_IDX, ctrlExp, "ctrl");
        rdChk(`DTC_LEN_IDX, curLen, "length");
    endtask : fin

    task automatic close_out;
        $display("mismatches %0d comparisons %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        #800000;
        num_errors++;
        close_out();
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge clock);
        #1 rst_n = 1'b1;
        cmp16("idleOutputs", 16'h0000, {13'h0, serviceReq, rdReq, wrValid});
        rdChk(`DTC_LEN_IDX, `DTC_LEN_RESET, "lengthReset");
        rdChk(`DTC_CTRL_IDX, `DTC_CTRL_RESET, "ctrlReset");
        wr(16'h0006, 16'hffff);
        rdChk(16'h0006, 16'h0000, "unmapped");
        wr(`DTC_LEN_IDX, 16'h0010);
        rdChk(`DTC_CTRL_IDX, 16'h4000, "status");
        wr(`DTC_LEN_IDX, 16'h0000);
        rdChk(`DTC_CTRL_IDX, 16'h0000, "status");
        wr(`DTC_CTRL_IDX, 16'h4002);
        rdChk(`DTC_CTRL_IDX, 16'h0000, "readOnly");
        // Plain block, one word per service, completion interrupt
        go(16'h0010, 16'ha000);
        fin(4, 1, 4, 16'h2000);
        wr(`DTC_CTRL_IDX, 16'h0000);
        rdChk(`DTC_CTRL_IDX, 16'h4000, "status");
        // Fixed addresses, four-word bursts, slow far side, no interrupt
        slow = 1'b1;
        go(16'h0020, 16'h8290);
        fin(8, 0, 2, 16'h0290);
        slow = 1'b0;
        // Sixteen-word burst with the destination stalled, disabled mid-burst: the burst still drains
        wrHold = 1'b1;
        go(16'h0040, 16'h8020);
        for (int i = 0; i < 200 && ackCnt < 16; i++) @(posedge clock);
        clk(3);
        cmpCnt("reads", 16, ackCnt);
        cmp16("rdReqWrValid", 16'h0001, {14'h0, rdReq, wrValid});
        cmpCnt("stalledWrites", 0, wrCnt);
        wr(`DTC_CTRL_IDX, 16'h0020);
        wrHold = 1'b0;
        fin(16, 0, 1, 16'h0020);
        // Event-paced transfer
        go(16'h0008, 16'h8004);
        clk(10);
        cmpCnt("grants", 0, gntCnt);
        pulse();
        waitWr(1);
        pulse();
        fin(2, 0, 2, 16'h0004);
        // Automatic reload restarts from the start addresses
        go(16'h0008, 16'h9004);
        pulse();
        waitWr(1);
        pulse();
        waitWr(2);
        rdChk(`DTC_CTRL_IDX, 16'hd004, "reload");
        expSrc = srcStart;
        expDst = dstStart;
        pulse();
        waitWr(3);
        wr(`DTC_CTRL_IDX, 16'h0000);
        // Disabled channel ignores later events
        go(16'h0010, 16'h8004);
        pulse();
        waitWr(1);
        wr(`DTC_CTRL_IDX, 16'h0000);
        pulse();
        waitWr(1);
        rdChk(`DTC_CTRL_IDX, 16'h4000, "disabled");
        // Ping-pong: one length for both halves, interrupt at each half
        go(16'h0010, 16'ha001);
        fin(4, 2, 4, 16'h2003);
        close_out();
    end
endmodule : dtc_channel_test
